// ==== common/fcd_regs.vh ====
// command codes, unlock addresses and bus timing for the flash command host
// assumes a x16 asynchronous nor flash bus, word addressed
`ifndef FCD_REGS_VH
`define FCD_REGS_VH
`define FCD_ADDR_UNLOCK1   12'h555
`define FCD_ADDR_UNLOCK2   12'h2aa
`define FCD_ADDR_TABLE     12'h055
`define FCD_SECT_LSB       16
`define FCD_DATA_UNLOCK1   8'haa
`define FCD_DATA_UNLOCK2   8'h55
`define FCD_CMD_RESET      8'hf0
`define FCD_CMD_SR_READ    8'h70
`define FCD_CMD_SR_CLEAR   8'h71
`define FCD_CMD_PROGRAM    8'ha0
`define FCD_CMD_BUF_LOAD   8'h25
`define FCD_CMD_BUF_CONF   8'h29
`define FCD_CMD_ERASE      8'h80
`define FCD_CMD_CHIP_ERASE 8'h10
`define FCD_CMD_SECT_ERASE 8'h30
`define FCD_CMD_SUSPEND    8'hb0
`define FCD_CMD_RESUME     8'h30
`define FCD_CMD_PG_SUSPEND 8'h51
`define FCD_CMD_PG_RESUME  8'h50
`define FCD_CMD_BLANK      8'h33
`define FCD_CMD_TABLE      8'h98
`define FCD_CMD_ID         8'h90
`define FCD_CMD_SECURE     8'h88
`define FCD_CMD_EXIT_DATA  8'h00
// operation codes on op_i
`define FCD_OP_RESET       5'h00
`define FCD_OP_SR_READ     5'h01
`define FCD_OP_SR_CLEAR    5'h02
`define FCD_OP_PROGRAM     5'h03
`define FCD_OP_BUF_WRITE   5'h04
`define FCD_OP_BUF_ABORT   5'h05
`define FCD_OP_CHIP_ERASE  5'h06
`define FCD_OP_SECT_ERASE  5'h07
`define FCD_OP_SUSPEND     5'h08
`define FCD_OP_RESUME      5'h09
`define FCD_OP_PG_SUSPEND  5'h0a
`define FCD_OP_PG_RESUME   5'h0b
`define FCD_OP_BLANK       5'h0c
`define FCD_OP_TABLE       5'h0d
`define FCD_OP_ID          5'h0e
`define FCD_OP_SECURE      5'h0f
`define FCD_OP_SECURE_EXIT 5'h10
// bus timing: write strobe low time, high/setup time, read access time and clock period, in ns
`define FCD_T_WP_NS        35
`define FCD_T_WPH_NS       20
`define FCD_T_RD_NS        120
`define FCD_CLK_NS         10
`endif

// ==== tb/fcd_flash_model.sv ====
// behavioural x16 flash: logs bus writes, answers status and array reads
// assumes writes latch on the rising write strobe with chip enable low
`timescale 1ns/10ps
module fcd_flash_model (
    input  wire        ce_n_i,
    input  wire        we_n_i,
    input  wire        oe_n_i,
    input  wire        dq_oe_i,
    input  wire [25:0] a_i,
    input  wire [15:0] dq_i,
    output wire [15:0] dq_o
);
    reg  [25:0] la [0:255];
    reg  [15:0] ld [0:255];
    reg  [15:0] err = 16'h0030;
    reg  [15:0] last = 16'h0000;
    reg         sr_mode = 1'b0;
    integer     n_log = 0;
    wire        drive = !ce_n_i && !oe_n_i;
    wire [15:0] rd_val = sr_mode ? (16'h0080 | err) : (a_i[15:0] ^ 16'h5a5a);

    // a released bus shows the inverse of the last word, never a stale copy
    assign dq_o = drive ? rd_val : ~last;
    always @(*) if (drive) last = rd_val;

    // only low address bits and the low data byte decode
    // other sequences are logged whole for the bench
    always @(posedge we_n_i) begin
        if (!ce_n_i && dq_oe_i) begin
            la[n_log] = a_i;
            ld[n_log] = dq_i;
            n_log = n_log + 1;
            sr_mode = (a_i[11:0] == 12'h555) && (dq_i[7:0] == 8'h70);
            if (a_i[11:0] == 12'h555 && dq_i[7:0] == 8'h71)
                err = 16'h0000;
        end
    end

    // the read after a status command ends status mode
    always @(posedge oe_n_i) sr_mode = 1'b0;
endmodule

// ==== tb/fcd_host_checker.sv ====
// bus-cycle assertions for the flash command host, bound to its ports
// assumes one clock domain and an active-low asynchronous reset
`timescale 1ns/10ps
module fcd_host_checker #(parameter AW = 26, parameter CW = 9) (
    input wire          clk_i,
    input wire          nrst_i,
    input wire          go_i,
    input wire [4:0]    op_i,
    input wire [AW-1:0] addr_i,
    input wire [15:0]   data_i,
    input wire [CW-1:0] count_i,
    input wire          word_valid_i,
    input wire [AW-1:0] word_addr_i,
    input wire [15:0]   word_data_i,
    input wire [15:0]   dq_i,
    input wire          busy_o,
    input wire          done_o,
    input wire          word_ready_o,
    input wire          rd_valid_o,
    input wire [15:0]   rd_data_o,
    input wire [AW-1:0] a_o,
    input wire [15:0]   dq_o,
    input wire          dq_oe_o,
    input wire          ce_n_o,
    input wire          we_n_o,
    input wire          oe_n_o
);
    // everything sampled on the rising clock, quiet during reset
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    // strobe shape and qualifiers of every bus write and read
    idle_bus_quiet_a: assert property (!busy_o |-> ce_n_o && we_n_o) else $error("bus active while idle");
    strobe_low_a: assert property ($fell(we_n_o) |-> !we_n_o [*4] ##1 we_n_o) else $error("write strobe width");
    strobe_high_a: assert property ($rose(we_n_o) |-> we_n_o [*2]) else $error("write strobe gap");
    write_hold_a: assert property (!we_n_o && !$fell(we_n_o) |-> $stable(a_o) && $stable(dq_o))
        else $error("address or data moved in write");
    write_qual_a: assert property (!we_n_o |-> !ce_n_o && oe_n_o && dq_oe_o) else $error("write not qualified");
    read_qual_a: assert property (!oe_n_o |-> !ce_n_o && we_n_o && !dq_oe_o) else $error("read not qualified");
    // request handshake
    busy_start_a: assert property (go_i && !busy_o |=> busy_o) else $error("request not taken");
    done_end_a: assert property (done_o |-> !busy_o && $past(busy_o)) else $error("done without busy");
    word_taken_a: assert property (word_ready_o |-> $past(word_valid_i)) else $error("word taken unoffered");
    // first write of selected commands
    reset_cmd_a: assert property (go_i && !busy_o && op_i == 5'h00 |-> ##[1:12] !we_n_o && dq_o[7:0] == 8'hf0)
        else $error("reset write missing");
    status_cmd_a: assert property (go_i && !busy_o && op_i == 5'h01 |-> ##[1:12] !we_n_o && a_o[11:0] == 12'h555
        && dq_o[7:0] == 8'h70) else $error("status write missing");
endmodule

bind fcd_host fcd_host_checker #(.AW(AW), .CW(CW)) chk_u (.clk_i(clk_i), .nrst_i(nrst_i), .go_i(go_i),
    .op_i(op_i), .addr_i(addr_i), .data_i(data_i), .count_i(count_i), .word_valid_i(word_valid_i),
    .word_addr_i(word_addr_i), .word_data_i(word_data_i), .dq_i(dq_i), .busy_o(busy_o), .done_o(done_o),
    .word_ready_o(word_ready_o), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .a_o(a_o), .dq_o(dq_o),
    .dq_oe_o(dq_oe_o), .ce_n_o(ce_n_o), .we_n_o(we_n_o), .oe_n_o(oe_n_o));

// ==== tb/test_fcd_host.sv ====
// self-checking bench: compares flash-side writes with a bench model
// assumes fcd_host, fcd_flash_model and the bound checker are compiled
`timescale 1ns/10ps
`include "fcd_regs.vh"
module test_fcd_host;
    reg         clk_i = 1'b0, nrst_i = 1'b0, go_i = 1'b0, word_valid_i = 1'b0;
    reg  [4:0]  op_i = 5'h00;
    reg  [25:0] addr_i = 26'h0, word_addr_i = 26'h0;
    reg  [15:0] data_i = 16'h0, word_data_i = 16'h0, rd_seen;
    reg  [8:0]  count_i = 9'h001;
    reg  [25:0] ea [0:15], em [0:15], wa [0:7];
    reg  [15:0] ed [0:15], dm [0:15], wd [0:7];
    wire [15:0] dq_i, dq_o, rd_data_o;
    wire [25:0] a_o;
    wire        busy_o, done_o, word_ready_o, rd_valid_o, dq_oe_o, ce_n_o, we_n_o, oe_n_o;
    integer     num_errors = 0, n_tests = 0, n_exp, i, j, k, widx, fin, seed;

    // host and flash model face each other on the parallel bus
    fcd_host dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .go_i(go_i), .op_i(op_i), .addr_i(addr_i), .data_i(data_i),
        .count_i(count_i), .word_valid_i(word_valid_i), .word_addr_i(word_addr_i), .word_data_i(word_data_i),
        .dq_i(dq_i), .busy_o(busy_o), .done_o(done_o), .word_ready_o(word_ready_o), .rd_valid_o(rd_valid_o),
        .rd_data_o(rd_data_o), .a_o(a_o), .dq_o(dq_o), .dq_oe_o(dq_oe_o), .ce_n_o(ce_n_o), .we_n_o(we_n_o),
        .oe_n_o(oe_n_o));
    fcd_flash_model model_u (.ce_n_i(ce_n_o), .we_n_i(we_n_o), .oe_n_i(oe_n_o), .dq_oe_i(dq_oe_o), .a_i(a_o),
        .dq_i(dq_o), .dq_o(dq_i));

    always #5 clk_i = ~clk_i;

    task end_sim;
        begin
            $display("checks %0d mismatches %0d", n_tests, num_errors);
            if (num_errors == 0 && n_tests > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask

    task check(input [25:0] exp, input [25:0] got, input [63:0] what);
        begin
            n_tests = n_tests + 1;
            if (exp !== got) begin
                num_errors = num_errors + 1;
                $display("wrong value %0s expected %h seen %h", what, exp, got);
            end
        end
    endtask

    // expected write: address, address mask, data, data mask
    task push(input [25:0] a, input [25:0] am, input [15:0] d, input [15:0] d_m);
        begin
            ea[n_exp] = a;
            em[n_exp] = am;
            ed[n_exp] = d;
            dm[n_exp] = d_m;
            n_exp = n_exp + 1;
        end
    endtask
    task cmd(input [25:0] a, input [7:0] d);
        push(a, 26'h0000fff, {8'h00, d}, 16'h00ff);
    endtask
    task unl;
        begin
            cmd(26'h555, 8'haa);
            cmd(26'h2aa, 8'h55);
        end
    endtask

    // build the expected writes, run one op, then compare the logged bus writes
    task run(input [4:0] op, input [25:0] ad, input [15:0] dat, input [8:0] cnt);
        integer start;
        begin
            n_exp = 0;
            case (op)
                `FCD_OP_SR_READ:    cmd(26'h555, 8'h70);
                `FCD_OP_SR_CLEAR:   cmd(26'h555, 8'h71);
                `FCD_OP_PROGRAM:    begin unl; cmd(26'h555, 8'ha0); push(ad, 26'h3ffffff, dat, 16'hffff); end
                `FCD_OP_BUF_WRITE:  begin
                    unl;
                    push(ad, 26'h3ff0000, 16'h0025, 16'h00ff);
                    push(ad, 26'h3ff0000, {7'h00, cnt - 9'h001}, 16'h00ff);
                    for (k = 0; k < cnt; k = k + 1)
                        push({ad[25:16], wa[k][15:0]}, 26'h3ffffff, wd[k], 16'hffff);
                    push(ad, 26'h3ff0000, 16'h0029, 16'h00ff);
                end
                `FCD_OP_BUF_ABORT:  begin unl; cmd(26'h555, 8'hf0); end
                `FCD_OP_CHIP_ERASE: begin unl; cmd(26'h555, 8'h80); unl; cmd(26'h555, 8'h10); end
                `FCD_OP_SECT_ERASE: begin unl; cmd(26'h555, 8'h80); unl; push(ad, 26'h3ff0000, 16'h0030, 16'h00ff); end
                `FCD_OP_SUSPEND:    push(26'h0, 26'h0, 16'h00b0, 16'h00ff);
                `FCD_OP_RESUME:     push(26'h0, 26'h0, 16'h0030, 16'h00ff);
                `FCD_OP_PG_SUSPEND: push(26'h0, 26'h0, 16'h0051, 16'h00ff);
                `FCD_OP_PG_RESUME:  push(26'h0, 26'h0, 16'h0050, 16'h00ff);
                `FCD_OP_BLANK:      push({ad[25:16], 16'h0555}, 26'h3ff0fff, 16'h0033, 16'h00ff);
                `FCD_OP_TABLE:      cmd(26'h055, 8'h98);
                `FCD_OP_ID:         begin unl; cmd(26'h555, 8'h90); end
                `FCD_OP_SECURE:     begin unl; cmd(26'h555, 8'h88); end
                `FCD_OP_SECURE_EXIT: begin unl; cmd(26'h555, 8'h90); push(26'h0, 26'h0, 16'h0000, 16'h00ff); end
                default:            push(26'h0, 26'h0, 16'h00f0, 16'h00ff);
            endcase
            start = model_u.n_log;
            widx = 0;
            fin = 0;
            rd_seen = 16'hxxxx;
            @(posedge clk_i);
            go_i <= 1'b1;
            op_i <= op;
            addr_i <= ad;
            data_i <= dat;
            count_i <= cnt;
            // a second request while busy must be ignored; words offered late to stall the host
            for (i = 0; i < 4000 && !fin; i = i + 1) begin
                @(negedge clk_i);
                if (done_o === 1'b1) fin = 1;
                if (rd_valid_o === 1'b1) rd_seen = rd_data_o;
                if (word_ready_o === 1'b1) widx = widx + 1;
                @(posedge clk_i);
                go_i <= (i == 30) && !fin;
                word_valid_i <= (op == `FCD_OP_BUF_WRITE) && (widx < cnt) && (i > 40);
                word_addr_i <= wa[widx[2:0]];
                word_data_i <= wd[widx[2:0]];
            end
            if (!fin) begin
                num_errors = num_errors + 1;
                $display("wrong value done expected 1 seen 0");
                end_sim;
            end
            k = model_u.n_log - start;
            check(n_exp[25:0], k[25:0], "writes");
            for (k = 0; k < n_exp; k = k + 1) begin
                check(ea[k] & em[k], model_u.la[start + k] & em[k], "address");
                check({10'h0, ed[k] & dm[k]}, {10'h0, model_u.ld[start + k] & dm[k]}, "data");
            end
        end
    endtask

    // reset, status read and clear, buffer count boundaries, then every op code
    initial begin
        seed = $urandom(32'h60f40754);
        for (k = 0; k < 8; k = k + 1) begin
            wa[k] = $urandom;
            wd[k] = $urandom;
        end
        repeat (16) @(posedge clk_i);
        nrst_i <= 1'b1;
        run(`FCD_OP_SR_READ, 26'h0, 16'h0, 9'h001);
        check(26'h00b0, {10'h0, rd_seen}, "status");
        run(`FCD_OP_SR_CLEAR, 26'h0, 16'h0, 9'h001);
        run(`FCD_OP_SR_READ, 26'h0, 16'h0, 9'h001);
        check(26'h0080, {10'h0, rd_seen}, "status");
        run(`FCD_OP_BUF_WRITE, $urandom, 16'h0, 9'h001);
        run(`FCD_OP_BUF_WRITE, $urandom, 16'h0, 9'h008);
        for (j = 0; j < 18; j = j + 1)
            run(j[4:0], $urandom, $urandom, 9'h001 + $urandom % 8);
        end_sim;
    end
endmodule

// ==== verilog/fcd_host.v ====
// host side command sequencer for a x16 nor flash on an asynchronous bus
// assumes the flash decodes writes on the rising edge of its write strobe;
// op_i/addr_i/data_i come from a synchronous user, one request per go_i pulse
//
// Contract
// - one write of f0 anywhere ends overlay or id mode, back to array read
// - write 70 to 555, then the next read returns the status register
// - one write of 71 to 555 clears status error flags
// - word program: aa/555, 55/2aa, a0/555, data to target address
// - buffer write: unlocks, 25 to sector, count to sector, then words in sector
// - 29 to the same sector confirms and starts buffer programming
// - abort recovery: aa/555, 55/2aa, f0/555 returns to read mode
// - chip erase: aa,55,80,aa,55 then 10 to 555
// - sector erase: same five leading writes, then 30 inside the sector
// - legacy suspend: one write of b0 anywhere
// - legacy resume: one write of 30 anywhere
// - enhanced program suspend 51, program resume 50, single writes
// - blank check: 33 to offset 555 inside the chosen sector
// - 98 to offset 55 enters parameter table reads
// - id entry: aa/555, 55/2aa, 90/555 within sector
// - secure region entry: aa/555, 55/2aa, 88/555
// - secure exit: aa/555, 55/2aa, 90/555, 00 anywhere
`timescale 1ns/10ps
`include "fcd_regs.vh"

module fcd_host #(
    parameter AW        = 26,
    parameter CW        = 9,
    parameter WP_CYC    = (`FCD_T_WP_NS + `FCD_CLK_NS - 1) / `FCD_CLK_NS,
    parameter WPH_CYC   = (`FCD_T_WPH_NS + `FCD_CLK_NS - 1) / `FCD_CLK_NS,
    parameter RD_CYC    = (`FCD_T_RD_NS + `FCD_CLK_NS - 1) / `FCD_CLK_NS
) (
    input  wire          clk_i,
    input  wire          nrst_i,
    input  wire          go_i,
    input  wire [4:0]    op_i,
    input  wire [AW-1:0] addr_i,
    input  wire [15:0]   data_i,
    input  wire [CW-1:0] count_i,
    input  wire          word_valid_i,
    input  wire [AW-1:0] word_addr_i,
    input  wire [15:0]   word_data_i,
    input  wire [15:0]   dq_i,
    output reg           busy_o,
    output reg           done_o,
    output reg           word_ready_o,
    output reg           rd_valid_o,
    output reg  [15:0]   rd_data_o,
    output reg  [AW-1:0] a_o,
    output reg  [15:0]   dq_o,
    output reg           dq_oe_o,
    output reg           ce_n_o,
    output reg           we_n_o,
    output reg           oe_n_o
);

    // one-hot sequencer states
    localparam [4:0] S_IDLE  = 5'b00001;
    localparam [4:0] S_SETUP = 5'b00010;
    localparam [4:0] S_PULSE = 5'b00100;
    localparam [4:0] S_HOLD  = 5'b01000;
    localparam [4:0] S_READ  = 5'b10000;

    localparam [AW-1:0] UL1 = {{(AW-12){1'b0}}, `FCD_ADDR_UNLOCK1};
    localparam [AW-1:0] UL2 = {{(AW-12){1'b0}}, `FCD_ADDR_UNLOCK2};
    localparam [AW-1:0] TBL = {{(AW-12){1'b0}}, `FCD_ADDR_TABLE};
    // sector field lives above the 64k-word offset
    localparam SB = `FCD_SECT_LSB;

    // request latched at go; step counts write cycles within the sequence, except that all buffered words share step 4
    reg [4:0]    state;
    reg [4:0]    op;
    reg [3:0]    step;
    reg [3:0]    nsteps;
    reg [AW-1:0] addr;
    reg [15:0]   data;
    reg [CW-1:0] left;
    reg [7:0]    tmr;
    reg          rd_after;

    // sector base of the request, low offset bits cleared
    wire [AW-1:0] sect = {addr[AW-1:SB], {SB{1'b0}}};

    // write cycle decoded for the current step
    reg [AW-1:0] cyc_a;
    reg [7:0]    cyc_d;
    reg          cyc_word;
    reg [3:0]    cyc_n;

    // address/data of the current write cycle; commands use low byte only
    always @* begin
        cyc_a    = {AW{1'b0}};
        cyc_d    = `FCD_CMD_RESET;
        cyc_word = 1'b0;
        cyc_n    = 4'd1;
        case (op)
            `FCD_OP_RESET: begin
                cyc_d = `FCD_CMD_RESET;
            end
            // single writes to the fixed unlock address
            `FCD_OP_SR_READ: begin
                cyc_a = UL1;
                cyc_d = `FCD_CMD_SR_READ;
            end
            `FCD_OP_SR_CLEAR: begin
                cyc_a = UL1;
                cyc_d = `FCD_CMD_SR_CLEAR;
            end
            // suspend and resume accept any address; 0 is used
            `FCD_OP_SUSPEND:    cyc_d = `FCD_CMD_SUSPEND;
            `FCD_OP_RESUME:     cyc_d = `FCD_CMD_RESUME;
            `FCD_OP_PG_SUSPEND: cyc_d = `FCD_CMD_PG_SUSPEND;
            `FCD_OP_PG_RESUME:  cyc_d = `FCD_CMD_PG_RESUME;
            `FCD_OP_BLANK: begin
                cyc_a = sect | UL1;
                cyc_d = `FCD_CMD_BLANK;
            end
            `FCD_OP_TABLE: begin
                cyc_a = sect | TBL;
                cyc_d = `FCD_CMD_TABLE;
            end
            default: begin
                // multi-cycle sequences open with the two unlock writes
                cyc_n = 4'd3;
                if (step == 4'd0 || step == 4'd3) begin
                    cyc_a = UL1;
                    cyc_d = `FCD_DATA_UNLOCK1;
                end else if (step == 4'd1 || step == 4'd4) begin
                    cyc_a = UL2;
                    cyc_d = `FCD_DATA_UNLOCK2;
                end
                case (op)
                    `FCD_OP_PROGRAM: begin
                        cyc_n = 4'd4;
                        if (step == 4'd2) begin
                            cyc_a = UL1;
                            cyc_d = `FCD_CMD_PROGRAM;
                        end else if (step == 4'd3) begin
                            cyc_a    = addr;
                            cyc_word = 1'b1;
                        end
                    end
                    `FCD_OP_BUF_WRITE: begin
                        // steps: 2 load cmd, 3 count, 4 words, 5 confirm
                        cyc_n = 4'd6;
                        if (step == 4'd2) begin
                            cyc_a = sect;
                            cyc_d = `FCD_CMD_BUF_LOAD;
                        end else if (step == 4'd3) begin
                            cyc_a = sect;
                            cyc_d = left[7:0] - 8'h01;            // count minus one
                        end else if (step == 4'd4) begin
                            cyc_a    = {addr[AW-1:SB], word_addr_i[SB-1:0]};
                            cyc_word = 1'b1;                      // kept in sector
                        end else if (step == 4'd5) begin
                            cyc_a = sect;
                            cyc_d = `FCD_CMD_BUF_CONF;
                        end
                    end
                    // recovery after a broken buffer load ends in the reset code
                    `FCD_OP_BUF_ABORT: begin
                        if (step == 4'd2) begin
                            cyc_a = UL1;
                            cyc_d = `FCD_CMD_RESET;
                        end
                    end
                    `FCD_OP_CHIP_ERASE, `FCD_OP_SECT_ERASE: begin
                        cyc_n = 4'd6;
                        if (step == 4'd2) begin
                            cyc_a = UL1;
                            cyc_d = `FCD_CMD_ERASE;
                        end else if (step == 4'd5) begin
                            if (op == `FCD_OP_CHIP_ERASE) begin
                                cyc_a = UL1;
                                cyc_d = `FCD_CMD_CHIP_ERASE;
                            end else begin
                                cyc_a = addr;
                                cyc_d = `FCD_CMD_SECT_ERASE;
                            end
                        end
                    end
                    `FCD_OP_ID: begin
                        if (step == 4'd2) begin
                            cyc_a = sect | UL1;
                            cyc_d = `FCD_CMD_ID;
                        end
                    end
                    `FCD_OP_SECURE: begin
                        if (step == 4'd2) begin
                            cyc_a = sect | UL1;
                            cyc_d = `FCD_CMD_SECURE;
                        end
                    end
                    // secure exit closes with a 00 write, placed at address 0
                    `FCD_OP_SECURE_EXIT: begin
                        cyc_n = 4'd4;
                        if (step == 4'd2) begin
                            cyc_a = UL1;
                            cyc_d = `FCD_CMD_ID;
                        end else if (step == 4'd3) begin
                            cyc_a = {AW{1'b0}};
                            cyc_d = `FCD_CMD_EXIT_DATA;
                        end
                    end
                    default: begin
                        // unknown code falls back to a plain reset write
                        cyc_n = 4'd1;
                        cyc_a = {AW{1'b0}};
                        cyc_d = `FCD_CMD_RESET;
                    end
                endcase
            end
        endcase
    end

    // buffer word step waits for the user to offer a word
    wire word_step = (op == `FCD_OP_BUF_WRITE) && (step == 4'd4);
    wire launch_ok = !word_step || word_valid_i;

    // bus sequencer: setup, strobe low, strobe high, then next cycle
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            // bus released: strobes high, data lines not driven
            state        <= S_IDLE;
            op           <= 5'h00;
            step         <= 4'd0;
            nsteps       <= 4'd1;
            addr         <= {AW{1'b0}};
            data         <= 16'h0000;
            left         <= {CW{1'b0}};
            tmr          <= 8'h00;
            rd_after     <= 1'b0;
            busy_o       <= 1'b0;
            done_o       <= 1'b0;
            word_ready_o <= 1'b0;
            rd_valid_o   <= 1'b0;
            rd_data_o    <= 16'h0000;
            a_o          <= {AW{1'b0}};
            dq_o         <= 16'h0000;
            dq_oe_o      <= 1'b0;
            ce_n_o       <= 1'b1;
            we_n_o       <= 1'b1;
            oe_n_o       <= 1'b1;
        end else begin
            // one-cycle pulses drop unless set below
            done_o       <= 1'b0;
            word_ready_o <= 1'b0;
            rd_valid_o   <= 1'b0;
            case (state)
                S_IDLE: begin
                    // latch the whole request so the user may change its inputs
                    if (go_i) begin
                        op       <= op_i;
                        addr     <= addr_i;
                        data     <= data_i;
                        // a zero count would announce 256 words but load one; load one instead
                        if (count_i == {CW{1'b0}}) begin
                            left <= {{(CW-1){1'b0}}, 1'b1};
                        end else begin
                            left <= count_i;
                        end
                        step     <= 4'd0;
                        rd_after <= (op_i == `FCD_OP_SR_READ);
                        busy_o   <= 1'b1;
                        state    <= S_SETUP;
                    end
                end
                S_SETUP: begin
                    nsteps <= cyc_n;
                    if (launch_ok) begin
                        // word data goes out whole; commands drive low byte
                        a_o     <= cyc_a;
                        dq_o    <= cyc_word ? (word_step ? word_data_i : data) : {8'h00, cyc_d};
                        dq_oe_o <= 1'b1;
                        ce_n_o  <= 1'b0;
                        we_n_o  <= 1'b0;
                        tmr     <= WP_CYC[7:0];
                        if (word_step) begin
                            word_ready_o <= 1'b1;
                        end
                        state   <= S_PULSE;
                    end
                end
                S_PULSE: begin
                    // strobe stays low for the full write pulse
                    if (tmr <= 8'd1) begin
                        we_n_o <= 1'b1;                           // flash latches data here
                        tmr    <= WPH_CYC[7:0];
                        state  <= S_HOLD;
                    end else begin
                        tmr <= tmr - 8'd1;
                    end
                end
                S_HOLD: begin
                    // strobe high time; address and data still stand until chip enable rises
                    if (tmr <= 8'd1) begin
                        dq_oe_o <= 1'b0;
                        ce_n_o  <= 1'b1;
                        if (word_step && left > {{(CW-1){1'b0}}, 1'b1}) begin
                            left  <= left - {{(CW-1){1'b0}}, 1'b1};
                            state <= S_SETUP;                     // next buffered word
                        end else if (step + 4'd1 < nsteps) begin
                            step  <= step + 4'd1;
                            state <= S_SETUP;
                        end else if (rd_after) begin
                            // status read: next read cycle at any address
                            a_o    <= {AW{1'b0}};
                            ce_n_o <= 1'b0;
                            oe_n_o <= 1'b0;
                            tmr    <= RD_CYC[7:0];
                            state  <= S_READ;
                        end else begin
                            busy_o <= 1'b0;
                            done_o <= 1'b1;
                            state  <= S_IDLE;
                        end
                    end else begin
                        tmr <= tmr - 8'd1;
                    end
                end
                S_READ: begin
                    // wait out the access time before sampling the data lines
                    if (tmr <= 8'd1) begin
                        rd_data_o  <= dq_i;
                        rd_valid_o <= 1'b1;
                        ce_n_o     <= 1'b1;
                        oe_n_o     <= 1'b1;
                        busy_o     <= 1'b0;
                        done_o     <= 1'b1;
                        state      <= S_IDLE;
                    end else begin
                        tmr <= tmr - 8'd1;
                    end
                end
                default: begin
                    // illegal one-hot code: back to idle
                    state <= S_IDLE;
                end
            endcase
        end
    end

endmodule
